// *** cps_regs.vh ***
// constants, pin level codes and register map for the control pin block
`ifndef CPS_REGS_VH
`define CPS_REGS_VH
`define CPS_LVL_L 2'h0
`define CPS_LVL_R 2'h1
`define CPS_LVL_F 2'h2
`define CPS_LVL_H 2'h3
`define CPS_REG_CFG 4'h0
`define CPS_REG_STAT 4'h1
`define CPS_CFG_SRC_LSB 0
`define CPS_SRC_LOCK 2'h0
`define CPS_SRC_CARRIER 2'h1
`define CPS_SRC_INTR 2'h2
`define CPS_CFG_RST 2'h0
`define CPS_SMB_BASE 3'h5
`define CPS_SPI_ADDR_END 5'h07
`define CPS_SPI_DATA_END 5'h0f
`define CPS_SPI_BITS 5'h10
`define CPS_BYTE_BITS 4'h8
`endif

// *** cps_regmem.v ***
// small register memory with registered read data
`timescale 1ns/1ps
module cps_regmem #(
  parameter AW = 4,
  parameter DW = 8
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // cps_regmem

// *** cps_ctrl_pins.v ***
// control pin decode with spi and smbus target ports
`timescale 1ns/1ps
`include "cps_regs.vh"
module cps_ctrl_pins #(
  parameter AW = 4
) (
  input wire ref_clk,
  input wire srst,
  input wire [1:0] route_sel_code,
  input wire [1:0] cable_drive_swing_select,
  input wire [1:0] if_sel_code,
  input wire [1:0] target_addr_strap_lo,
  input wire [1:0] target_addr_strap_hi,
  input wire enable_pin,
  input wire enable_float,
  input wire reclk_locked,
  input wire carrier_det,
  input wire intr_req,
  input wire ss_n,
  input wire ss_n_float,
  input wire sck,
  input wire mosi,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg miso,
  output reg miso_oe,
  output reg lock_flag_out,
  output reg lock_flag_oe,
  output reg reclk_en,
  output reg eq_en,
  output reg [1:0] swing_sel,
  output reg power_down,
  output reg spi_sel,
  output reg smbus_sel,
  output reg [6:0] smb_addr
);
  localparam NS = 18;
  localparam S_IDLE = 4'h0;
  localparam S_ADDR = 4'h1;
  localparam S_AACK = 4'h2;
  localparam S_REG = 4'h3;
  localparam S_RACK = 4'h4;
  localparam S_WDAT = 4'h5;
  localparam S_WACK = 4'h6;
  localparam S_RDAT = 4'h7;
  localparam S_HACK = 4'h8;

  // every pin input except reclk_locked, carrier_det and intr_req crosses two flops before use
  wire [NS-1:0] raw;
  reg [NS-1:0] sy1;
  reg [NS-1:0] sy2;
  assign raw = {route_sel_code, cable_drive_swing_select, if_sel_code,
    target_addr_strap_lo, target_addr_strap_hi, enable_pin, enable_float,
    ss_n, ss_n_float, sck, mosi, scl, sda_in};

  always @(posedge ref_clk) begin
    sy1 <= raw;
    sy2 <= sy1;
  end

  wire [1:0] route_q = sy2[17:16];
  wire [1:0] swing_q = sy2[15:14];
  wire [1:0] ifsel_q = sy2[13:12];
  wire [1:0] strap_lo_q = sy2[11:10];
  wire [1:0] strap_hi_q = sy2[9:8];
  wire en_q = sy2[7] | sy2[6];
  wire ss_q = sy2[5] | sy2[4];
  wire sck_q = sy2[3];
  wire mosi_q = sy2[2];
  wire scl_q = sy2[1];
  wire sda_q = sy2[0];

  // third stage for edge finding, keeps the first flop private
  reg sck_d;
  reg scl_d;
  reg sda_d;
  wire sck_rise = sck_q & ~sck_d;
  wire sck_fall = ~sck_q & sck_d;
  wire scl_rise = scl_q & ~scl_d;
  wire scl_fall = ~scl_q & scl_d;
  wire smb_start = scl_q & sda_d & ~sda_q;
  wire smb_stop = scl_q & ~sda_d & sda_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      sck_d <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sck_d <= sck_q;
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  // straps caught once after reset release, then frozen
  reg strap_done;
  always @(posedge ref_clk) begin
    if (srst) begin
      strap_done <= 1'b0;
      smb_addr <= 7'h00;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      smb_addr <= {`CPS_SMB_BASE, strap_hi_q, strap_lo_q};
    end
  end

  // pin decode
  reg [1:0] lock_sel;
  wire next_pd = ~en_q;
  always @(posedge ref_clk) begin
    if (srst) begin
      reclk_en <= 1'b0;
      eq_en <= 1'b0;
      swing_sel <= 2'h0;
      power_down <= 1'b0;
      spi_sel <= 1'b0;
      smbus_sel <= 1'b0;
    end else begin
      power_down <= next_pd;
      spi_sel <= (ifsel_q == `CPS_LVL_F);
      smbus_sel <= (ifsel_q == `CPS_LVL_L);
      swing_sel <= swing_q;
      case (route_q)
        `CPS_LVL_L: begin
          reclk_en <= ~next_pd;
          eq_en <= ~next_pd;
        end
        `CPS_LVL_R: begin
          reclk_en <= 1'b0;
          eq_en <= ~next_pd;
        end
        `CPS_LVL_F: begin
          reclk_en <= ~next_pd;
          eq_en <= 1'b0;
        end
        default: begin
          reclk_en <= 1'b0;
          eq_en <= 1'b0;
        end
      endcase
    end
  end

  // open-drain lock flag, only ever pulled low
  reg flag_src;
  always @* begin
    case (lock_sel)
      `CPS_SRC_CARRIER: flag_src = carrier_det;
      `CPS_SRC_INTR: flag_src = intr_req;
      default: flag_src = reclk_locked;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      lock_flag_out <= 1'b0;
      lock_flag_oe <= 1'b0;
    end else begin
      lock_flag_out <= 1'b0;
      lock_flag_oe <= flag_src;
    end
  end

  // register access shared by both ports
  reg spi_we;
  reg [AW-1:0] spi_wa;
  reg [7:0] spi_wd;
  reg smb_we;
  reg [7:0] smb_off;
  reg [7:0] smb_wd;
  reg [AW-1:0] spi_addr;
  reg [AW-1:0] rsel;
  wire [7:0] mem_rd;
  wire wr_en = spi_we | smb_we;
  wire [AW-1:0] wr_addr = smb_we ? smb_off[AW-1:0] : spi_wa;
  wire [7:0] wr_data = smb_we ? smb_wd : spi_wd;
  wire [AW-1:0] rd_addr = smbus_sel ? smb_off[AW-1:0] : spi_addr;
  wire [7:0] status = {4'h0, power_down, intr_req, carrier_det, reclk_locked};
  reg [7:0] rdata;

  cps_regmem #(
    .AW(AW),
    .DW(8)
  ) u_mem (
    .clk(ref_clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(mem_rd)
  );

  always @(posedge ref_clk) begin
    if (srst) begin
      rsel <= {AW{1'b0}};
      lock_sel <= `CPS_CFG_RST;
    end else begin
      rsel <= rd_addr;
      if (wr_en && wr_addr == `CPS_REG_CFG) begin
        lock_sel <= wr_data[`CPS_CFG_SRC_LSB+1:`CPS_CFG_SRC_LSB];
      end
    end
  end

  always @* begin
    if (rsel == `CPS_REG_CFG) begin
      rdata = {6'h00, lock_sel};
    end else if (rsel == `CPS_REG_STAT) begin
      rdata = status;
    end else begin
      rdata = mem_rd;
    end
  end

  // spi target: rw bit, 7 address bits, 8 data bits, msb first
  reg [4:0] spi_cnt;
  reg [7:0] spi_sh;
  reg [7:0] spi_tx;
  reg spi_rd;
  always @(posedge ref_clk) begin
    if (srst) begin
      spi_cnt <= 5'h00;
      spi_sh <= 8'h00;
      spi_tx <= 8'h00;
      spi_rd <= 1'b0;
      spi_addr <= {AW{1'b0}};
      spi_we <= 1'b0;
      spi_wa <= {AW{1'b0}};
      spi_wd <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      spi_we <= 1'b0;
      if (!spi_sel || ss_q) begin
        spi_cnt <= 5'h00;
        spi_tx <= 8'h00;
        miso <= 1'b0;
        miso_oe <= 1'b0;
      end else begin
        miso_oe <= 1'b1;
        if (sck_rise && spi_cnt != `CPS_SPI_BITS) begin
          spi_sh <= {spi_sh[6:0], mosi_q};
          spi_cnt <= spi_cnt + 5'h01;
          if (spi_cnt == `CPS_SPI_ADDR_END) begin
            spi_rd <= spi_sh[6];
            spi_addr <= {spi_sh[AW-2:0], mosi_q};
          end
          if (spi_cnt == `CPS_SPI_DATA_END && !spi_rd) begin
            spi_we <= 1'b1;
            spi_wa <= spi_addr;
            spi_wd <= {spi_sh[6:0], mosi_q};
          end
        end
        // miso moves on falling sck so it is steady at the host's rising edge
        if (sck_fall) begin
          if (spi_cnt == {1'b0, `CPS_BYTE_BITS} && spi_rd) begin
            miso <= rdata[7];
            spi_tx <= {rdata[6:0], 1'b0};
          end else begin
            miso <= spi_tx[7];
            spi_tx <= {spi_tx[6:0], 1'b0};
          end
        end
      end
    end
  end

  // smbus target, device never starts a transfer
  reg [3:0] smb_st;
  reg [3:0] smb_cnt;
  reg [7:0] smb_sh;
  reg [7:0] smb_tx;
  reg smb_rw;
  always @(posedge ref_clk) begin
    if (srst) begin
      smb_st <= S_IDLE;
      smb_cnt <= 4'h0;
      smb_sh <= 8'h00;
      smb_tx <= 8'h00;
      smb_rw <= 1'b0;
      smb_off <= 8'h00;
      smb_we <= 1'b0;
      smb_wd <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      smb_we <= 1'b0;
      sda_out <= 1'b0;
      if (!smbus_sel || smb_stop) begin
        smb_st <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (smb_start) begin
        smb_st <= S_ADDR;
        smb_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (smb_st == S_ADDR || smb_st == S_REG || smb_st == S_WDAT) begin
          smb_sh <= {smb_sh[6:0], sda_q};
          smb_cnt <= smb_cnt + 4'h1;
        end else if (smb_st == S_RDAT) begin
          smb_cnt <= smb_cnt + 4'h1;
        end else if (smb_st == S_HACK && sda_q) begin
          smb_st <= S_IDLE; // host nack ends the read
        end
      end else if (scl_fall) begin
        case (smb_st)
          S_ADDR: begin
            if (smb_cnt == `CPS_BYTE_BITS) begin
              if (smb_sh[7:1] == smb_addr) begin
                smb_rw <= smb_sh[0];
                sda_oe <= 1'b1;
                smb_st <= S_AACK;
              end else begin
                smb_st <= S_IDLE;
              end
            end
          end
          S_REG: begin
            if (smb_cnt == `CPS_BYTE_BITS) begin
              smb_off <= smb_sh;
              sda_oe <= 1'b1;
              smb_st <= S_RACK;
            end
          end
          S_WDAT: begin
            if (smb_cnt == `CPS_BYTE_BITS) begin
              smb_we <= 1'b1;
              smb_wd <= smb_sh;
              sda_oe <= 1'b1;
              smb_st <= S_WACK;
            end
          end
          S_WACK: begin
            // offset steps after the write pulse has used it
            smb_off <= smb_off + 8'h01;
            sda_oe <= 1'b0;
            smb_cnt <= 4'h0;
            smb_st <= S_WDAT;
          end
          S_RACK: begin
            sda_oe <= 1'b0;
            smb_cnt <= 4'h0;
            smb_st <= S_WDAT;
          end
          S_AACK, S_HACK: begin
            smb_cnt <= 4'h0;
            if (smb_st == S_AACK && !smb_rw) begin
              sda_oe <= 1'b0;
              smb_st <= S_REG;
            end else begin
              sda_oe <= ~rdata[7];
              smb_tx <= {rdata[6:0], 1'b1};
              smb_st <= S_RDAT;
            end
          end
          S_RDAT: begin
            if (smb_cnt == `CPS_BYTE_BITS) begin
              sda_oe <= 1'b0;
              smb_off <= smb_off + 8'h01;
              smb_st <= S_HACK;
            end else begin
              sda_oe <= ~smb_tx[7];
              smb_tx <= {smb_tx[6:0], 1'b1};
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // cps_ctrl_pins

// *** cps_ctrl_pins_properties.sv ***
// checker for the control pin block outputs
`timescale 1ns/1ps
module cps_chk (
  input logic ref_clk,
  input logic srst,
  input logic [1:0] route_sel_code,
  input logic [1:0] cable_drive_swing_select,
  input logic [1:0] if_sel_code,
  input logic enable_pin,
  input logic enable_float,
  input logic ss_n,
  input logic ss_n_float,
  input logic sda_out,
  input logic sda_oe,
  input logic miso_oe,
  input logic lock_flag_out,
  input logic reclk_en,
  input logic eq_en,
  input logic [1:0] swing_sel,
  input logic power_down,
  input logic spi_sel,
  input logic smbus_sel,
  input logic [6:0] smb_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // five samples cover the three edge pin latency
  pd_on_a: assert property ((!enable_pin && !enable_float)[*5] |-> power_down)
    else $error("power down missing");
  pd_off_a: assert property ((enable_pin || enable_float)[*5] |-> !power_down)
    else $error("power down while enabled");
  route_dec_a: assert property ((enable_pin && $stable(route_sel_code))[*5]
    |-> reclk_en == !route_sel_code[0] && eq_en == !route_sel_code[1]) else $error("bad route");
  swing_copy_a: assert property ($stable(cable_drive_swing_select)[*5]
    |-> swing_sel == cable_drive_swing_select) else $error("bad swing");
  port_sel_a: assert property ($stable(if_sel_code)[*5]
    |-> spi_sel == (if_sel_code == 2'h2) && smbus_sel == (if_sel_code == 2'h0))
    else $error("bad port select");
  drain_only_a: assert property (!lock_flag_out && !sda_out)
    else $error("open drain pin driven high");
  miso_idle_a: assert property ((ss_n || ss_n_float)[*5] |-> !miso_oe)
    else $error("miso driven while deselected");
  addr_hold_a: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(smb_addr))
    else $error("strap address moved");
  smb_quiet_a: assert property (!smbus_sel |=> !sda_oe)
    else $error("sda pulled outside smbus mode");
  cover property (sda_oe);
  cover property (power_down);
  cover property (miso_oe);
  cover property (smbus_sel);
endmodule // cps_chk

bind cps_ctrl_pins cps_chk chk_i (.ref_clk, .srst, .route_sel_code, .cable_drive_swing_select,
  .if_sel_code, .enable_pin, .enable_float, .ss_n, .ss_n_float, .sda_out, .sda_oe, .miso_oe,
  .lock_flag_out, .reclk_en, .eq_en, .swing_sel, .power_down, .spi_sel, .smbus_sel, .smb_addr);

// *** cps_spi_host.sv ***
// spi and smbus host model for the control port
`timescale 1ns/1ps
module cps_spi_host (
  input logic ref_clk,
  input logic miso,
  input logic miso_oe,
  input logic sda,
  output logic ss_n,
  output logic sck,
  output logic mosi,
  output logic scl,
  output logic sda_drv
);
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // mode 0, 125 ns clock, clock still outside frames
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    @(posedge ref_clk);
    ss_n <= 1'b0;
    // odd offset keeps every mosi and sck change off the clock edges
    #102;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #62.5 sck = 1'b1;
      if (i < 8) rx[i] = miso_oe ? miso : 1'bx;
      #62.5 sck = 1'b0;
    end
    // mosi released to its pull-up level
    #100 ss_n = 1'b1;
    mosi = 1'b1;
    #200;
  endtask
  // smbus controller, steps of five clocks keep scl low for ten
  task automatic smb_step();
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic smb_bit(input logic b, output logic s);
    sda_drv <= b;
    smb_step();
    scl <= 1'b1;
    smb_step();
    s = sda;
    scl <= 1'b0;
    smb_step();
  endtask
  task automatic smb_start();
    sda_drv <= 1'b1;
    smb_step();
    scl <= 1'b1;
    smb_step();
    sda_drv <= 1'b0;
    smb_step();
    scl <= 1'b0;
    smb_step();
  endtask
  task automatic smb_stop();
    sda_drv <= 1'b0;
    smb_step();
    scl <= 1'b1;
    smb_step();
    sda_drv <= 1'b1;
    smb_step();
  endtask
  // eight data bits then the ack slot; a released line reads back what the target drives
  task automatic smb_byte(input logic [7:0] tx, input logic ack, output logic [7:0] rb,
    output logic ak);
    for (int i = 7; i >= 0; i--) smb_bit(tx[i], rb[i]);
    smb_bit(ack, ak);
  endtask
endmodule // cps_spi_host

// *** testbench.sv ***
// testbench for the control pin block
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0;
  logic srst = 1;
  logic [1:0] route_sel_code = 2'h0, cable_drive_swing_select = 2'h0, if_sel_code = 2'h2;
  logic [1:0] target_addr_strap_lo = 2'h1, target_addr_strap_hi = 2'h2;
  logic enable_pin = 1, enable_float = 0, reclk_locked = 0, carrier_det = 0, intr_req = 0;
  logic ss_n_float = 0;
  wire ss_n, sck, mosi, scl, sda_drv;
  logic sda_out, sda_oe, miso, miso_oe, lock_flag_out, lock_flag_oe, reclk_en, eq_en;
  logic power_down, spi_sel, smbus_sel;
  logic [1:0] swing_sel;
  logic [6:0] smb_addr;
  logic [7:0] rx;
  int error_cnt = 0, samples_checked = 0;
  // open drain: either side pulls sda low, the pull-up gives the rest
  wire sda_in = sda_drv & !sda_oe;
  cps_ctrl_pins dut (.ref_clk, .srst, .route_sel_code, .cable_drive_swing_select, .if_sel_code,
    .target_addr_strap_lo, .target_addr_strap_hi, .enable_pin, .enable_float, .reclk_locked,
    .carrier_det, .intr_req, .ss_n, .ss_n_float, .sck, .mosi, .scl, .sda_in, .sda_out, .sda_oe,
    .miso, .miso_oe, .lock_flag_out, .lock_flag_oe, .reclk_en, .eq_en, .swing_sel, .power_down,
    .spi_sel, .smbus_sel, .smb_addr);
  cps_spi_host host (.ref_clk, .miso, .miso_oe, .sda(sda_in), .ss_n, .sck, .mosi, .scl,
    .sda_drv);
  always #5 ref_clk = ~ref_clk;
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    cyc(4);
    srst <= 1'b0;
    cyc(6);
  endtask
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      route_sel_code <= c[1:0];
      cable_drive_swing_select <= c[1:0];
      if_sel_code <= c[1:0];
      cyc(6);
      chk("route", {6'h0, ~c[0], ~c[1]}, {6'h0, reclk_en, eq_en});
      chk("swing", {6'h0, c[1:0]}, {6'h0, swing_sel});
      chk("ports", {6'h0, c == 2, c == 0}, {6'h0, spi_sel, smbus_sel});
    end
    if_sel_code <= 2'h2;
    route_sel_code <= 2'h0;
    enable_pin <= 1'b0;
    cyc(6);
    chk("pd", 8'h01, {7'h0, power_down});
    chk("route_pd", 8'h00, {6'h0, reclk_en, eq_en});
    enable_float <= 1'b1;
    cyc(6);
    chk("pd_float", 8'h00, {7'h0, power_down});
    enable_pin <= 1'b1;
    enable_float <= 1'b0;
  endtask
  task automatic t_lock();
    reclk_locked <= 1'b1;
    cyc(4);
    chk("lock", 8'h01, {7'h0, lock_flag_oe});
    chk("miso_idle", 8'h00, {7'h0, miso_oe});
    host.xfer(16'h8000, rx);
    chk("cfg_rst", 8'h00, rx);
    host.xfer(16'h0001, rx);
    cyc(4);
    chk("carrier_src", 8'h00, {7'h0, lock_flag_oe});
    host.xfer(16'h0002, rx);
    intr_req <= 1'b1;
    cyc(4);
    chk("intr_src", 8'h01, {7'h0, lock_flag_oe});
    host.xfer(16'h8000, rx);
    chk("cfg_rd", 8'h02, rx);
    host.xfer(16'h8100, rx);
    chk("status", 8'h05, rx);
    // far too short a frame would be dropped, so no partial frames here
    host.xfer(16'h0000, rx);
  endtask
  task automatic t_smbus();
    logic [7:0] rb;
    logic ak;
    if_sel_code <= 2'h0;
    cyc(6);
    host.smb_start();
    host.smb_byte(8'hba, 1'b1, rb, ak);
    chk("smb_other_ack", 8'h01, {7'h0, ak});
    host.smb_stop();
    host.smb_start();
    host.smb_byte(8'hb8, 1'b1, rb, ak);
    chk("smb_addr_ack", 8'h00, {7'h0, ak});
    host.smb_byte(8'h02, 1'b1, rb, ak);
    chk("smb_off_ack", 8'h00, {7'h0, ak});
    host.smb_byte(8'ha5, 1'b1, rb, ak);
    chk("smb_wr_ack", 8'h00, {7'h0, ak});
    host.smb_stop();
    host.smb_start();
    host.smb_byte(8'hb8, 1'b1, rb, ak);
    host.smb_byte(8'h02, 1'b1, rb, ak);
    host.smb_start();
    host.smb_byte(8'hb9, 1'b1, rb, ak);
    chk("smb_rd_ack", 8'h00, {7'h0, ak});
    host.smb_byte(8'hff, 1'b1, rb, ak);
    chk("smb_rd_data", 8'ha5, rb);
    host.smb_stop();
  endtask
  task automatic t_straps();
    chk("addr", 8'h59, {1'b0, smb_addr});
    target_addr_strap_hi <= 2'h3;
    target_addr_strap_lo <= 2'h0;
    cyc(6);
    chk("addr_hold", 8'h59, {1'b0, smb_addr});
    do_reset();
    chk("addr_new", 8'h5c, {1'b0, smb_addr});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    do_reset();
    t_straps();
    t_codes();
    t_lock();
    t_smbus();
    summarize();
  end
  // all scenarios take well under 60 us
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule // testbench
